/* rtl/uart_pkg.sv */
// uart_pkg: register map, field layout, frame constants and carriers for the serial block
// assumes a 50 MHz mclk and a 32-bit Avalon-MM slave with word addressing by byte address
package uart_pkg;

  localparam int unsigned    clk_hz           = 50000000;
  localparam int unsigned    oversample       = 16;
  localparam int unsigned    vote_samples     = 3;
  localparam int unsigned    break_zero_bits  = 13;

  localparam logic [7:0]     addr_data        = 8'h00;
  localparam logic [7:0]     addr_status      = 8'h04;
  localparam logic [7:0]     addr_format      = 8'h08;
  localparam logic [7:0]     addr_control     = 8'h0C;
  localparam logic [7:0]     addr_baud        = 8'h10;

  // format_control_reg fields
  localparam int unsigned    f_word_len       = 0;
  localparam int unsigned    f_par_en         = 1;
  localparam int unsigned    f_par_odd        = 2;
  localparam int unsigned    f_stop2          = 3;
  localparam int unsigned    f_tx9            = 4;
  localparam int unsigned    f_rx9            = 5;
  localparam logic [5:0]     format_reset     = 6'h00;

  // control fields
  localparam int unsigned    c_tx_en          = 0;
  localparam int unsigned    c_rx_en          = 1;
  localparam int unsigned    c_brk            = 2;
  localparam int unsigned    c_tx_ie          = 3;
  localparam int unsigned    c_rx_ie          = 4;
  localparam logic [4:0]     control_reset    = 5'h00;

  // line_status_reg fields
  localparam int unsigned    s_txe            = 0;
  localparam int unsigned    s_tidle          = 1;
  localparam int unsigned    s_rxa            = 2;
  localparam int unsigned    s_ovr            = 3;
  localparam int unsigned    s_noise          = 4;
  localparam int unsigned    s_par            = 5;
  localparam int unsigned    s_frm            = 6;
  localparam int unsigned    s_ridle          = 7;
  localparam int unsigned    s_irq            = 8;

  localparam logic [7:0]     baud_reset       = 8'h00;
  localparam logic [3:0]     tick_last        = 4'hF;
  localparam logic [3:0]     tick_mid         = 4'h7;
  localparam logic [3:0]     tick_vote0       = 4'h6;
  localparam logic [3:0]     tick_vote2       = 4'h8;
  localparam logic [4:0]     brk_count        = 5'h0D;

  typedef enum logic [2:0] {
    tx_idle  = 3'b000,
    tx_start = 3'b001,
    tx_data  = 3'b010,
    tx_par   = 3'b011,
    tx_stop  = 3'b100,
    tx_brk   = 3'b101
  } tx_state_t;

  typedef enum logic [2:0] {
    rx_hunt   = 3'b000,
    rx_start  = 3'b001,
    rx_data   = 3'b010,
    rx_par    = 3'b011,
    rx_stop   = 3'b100,
    rx_wait_h = 3'b101
  } rx_state_t;

  typedef struct packed {
    logic [9:0] data;
    logic       frm;
    logic       par;
    logic       noise;
  } rx_word_t;

endpackage

/* rtl/baud_tick.sv */
// baud_tick: divider making the 16x oversample enable
// assumes divider value is stable while frames are in progress
module baud_tick
  import uart_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] divider,
  output logic            tick
);

  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // one enable every divider+1 clocks
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count >= divider) begin
      next_st.count = 8'h00;
      next_st.tick  = 1'b1;
    end else begin
      next_st.count = st.count + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

/* rtl/async_serial_tx_rx.sv */
// async_serial_tx_rx: serial transceiver with Avalon-MM register slave
// assumes synchronous serial_in_pin; the far side keeps its own framing
module async_serial_tx_rx
  import uart_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [5:0]  format_control_reg;
    logic [4:0]  control;
    logic [7:0]  baud_divider_reg;
    logic        tx_buffer_empty_flag;
    logic        tx_idle_flag;
    logic        overrun_flag;
    logic        noise_flag;
    logic        parity_error_flag;
    logic        framing_error_flag;
    logic        rx_idle_flag;
    logic        stat_seen_tx;
    logic        stat_seen_rx;
    logic        ack;
    logic [31:0] rdata;
    logic [8:0]  tx_hold;
    logic        hold_full;
    tx_state_t   tx_st;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_tick;
    logic [4:0]  tx_bit;
    logic        tx_par;
    logic        tx_line;
    logic        tx_oe;
    logic [7:0]  brk_age;
    logic        brk_armed;
    rx_state_t   rx_st;
    logic [3:0]  rx_tick;
    logic [3:0]  rx_bit;
    logic [2:0]  votes;
    logic [9:0]  rx_shift_reg;
    logic        rx_noise;
    logic        rx_par;
    rx_word_t [1:0] fifo;
    logic [1:0]  fifo_cnt;
    logic        irq;
  } state_t;

  state_t st;
  state_t next_st;
  logic   tick;
  logic   vote;
  logic   word9;
  logic   sel_data;
  logic   sel_status;
  logic [3:0] nbits;
  rx_word_t   inw;
  logic       push;
  logic       pop;
  logic       tx_wr;

  baud_tick baud_tick_inst (
    .mclk    (mclk),
    .reset   (reset),
    .divider (st.baud_divider_reg),
    .tick    (tick)
  );

  // majority of three samples around mid bit
  assign vote  = (st.votes[0] & st.votes[1]) | (st.votes[1] & st.votes[2]) |
                 (st.votes[0] & st.votes[2]);
  assign word9 = st.format_control_reg[f_word_len];
  assign nbits = word9 ? 4'h9 : 4'h8;
  assign sel_data   = (avs_address == addr_data);
  assign sel_status = (avs_address == addr_status);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    push = 1'b0;
    pop  = 1'b0;
    inw  = '0;
    tx_wr = 1'b0;
    next_st.ack = 1'b0;

    // bus slave: one wait cycle, answer on the second
    if ((avs_read || avs_write) && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = 32'h00000000;
      if (avs_read) begin
        if (sel_data) begin
          next_st.rdata = {22'h000000, st.fifo[0].data};
          if (st.stat_seen_rx && st.fifo_cnt != 2'b00) begin
            pop = 1'b1;
            next_st.stat_seen_rx = 1'b0;
          end
        end else if (sel_status) begin
          next_st.rdata = {23'h000000, st.irq, st.rx_idle_flag, st.framing_error_flag,
                           st.parity_error_flag, st.noise_flag, st.overrun_flag,
                           (st.fifo_cnt != 2'b00), st.tx_idle_flag, st.tx_buffer_empty_flag};
          next_st.stat_seen_tx = 1'b1;
          next_st.stat_seen_rx = 1'b1;
        end else if (avs_address == addr_format) begin
          next_st.rdata = {26'h0000000, st.format_control_reg};
        end else if (avs_address == addr_control) begin
          next_st.rdata = {27'h0000000, st.control};
        end else if (avs_address == addr_baud) begin
          next_st.rdata = {24'h000000, st.baud_divider_reg};
        end
      end else begin
        if (sel_data && avs_byteenable[0]) begin
          if (st.tx_buffer_empty_flag) begin
            next_st.tx_hold = {st.format_control_reg[f_tx9], avs_writedata[7:0]};
            next_st.hold_full = 1'b1;
            tx_wr = 1'b1;
            if (st.stat_seen_tx) begin
              next_st.tx_buffer_empty_flag = 1'b0;
              next_st.tx_idle_flag = 1'b0;
              next_st.stat_seen_tx = 1'b0;
            end
          end
        end else if (avs_address == addr_format && avs_byteenable[0]) begin
          next_st.format_control_reg = {st.format_control_reg[f_rx9], avs_writedata[4:0]};
        end else if (avs_address == addr_control && avs_byteenable[0]) begin
          next_st.control = avs_writedata[4:0];
        end else if (avs_address == addr_baud && avs_byteenable[0]) begin
          next_st.baud_divider_reg = avs_writedata[7:0];
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // break request qualification: held beyond divider+1 clocks while idle
    if (st.control[c_brk] && st.tx_idle_flag) begin
      if (st.brk_age > st.baud_divider_reg) begin
        next_st.brk_armed = 1'b1;
      end else begin
        next_st.brk_age = st.brk_age + 8'h01;
      end
    end else if (!st.control[c_brk]) begin
      next_st.brk_age   = 8'h00;
      next_st.brk_armed = 1'b0;
    end

    next_st.tx_oe = st.control[c_tx_en];
    if (!st.control[c_tx_en]) begin
      next_st.tx_st = tx_idle;
      next_st.tx_line = 1'b1;
    end else begin
      case (st.tx_st)
        tx_idle: begin
          next_st.tx_line = 1'b1;
          // start only on a tick so the start bit lasts a whole bit time
          if (tick && st.brk_armed) begin
            next_st.tx_st = tx_start;
            next_st.tx_tick = 4'h0;
            next_st.tx_idle_flag = 1'b0;
            next_st.tx_line = 1'b0;
          end else if (tick && st.hold_full) begin
            next_st.tx_shift = st.tx_hold;
            next_st.tx_par = st.format_control_reg[f_par_odd];
            // a write in the same cycle keeps its word in the buffer
            next_st.hold_full = tx_wr;
            next_st.tx_buffer_empty_flag = next_st.tx_buffer_empty_flag | !tx_wr;
            next_st.tx_st = tx_start;
            next_st.tx_tick = 4'h0;
            next_st.tx_idle_flag = 1'b0;
            next_st.tx_line = 1'b0;
          end
        end
        default: begin
          if (tick) begin
            next_st.tx_tick = st.tx_tick + 4'h1;
            if (st.tx_tick == tick_last) begin
              case (st.tx_st)
                tx_start: begin
                  next_st.tx_bit = 5'h00;
                  if (st.brk_armed) begin
                    next_st.tx_st = tx_brk;
                    next_st.tx_line = 1'b0;
                  end else begin
                    next_st.tx_st = tx_data;
                    next_st.tx_line = st.tx_shift[0];
                  end
                end
                tx_data: begin
                  next_st.tx_par = st.tx_par ^ st.tx_shift[0];
                  next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
                  next_st.tx_bit = st.tx_bit + 5'h01;
                  if (st.tx_bit[3:0] == nbits - 4'h1) begin
                    if (st.format_control_reg[f_par_en]) begin
                      next_st.tx_st = tx_par;
                      next_st.tx_line = st.tx_par ^ st.tx_shift[0];
                    end else begin
                      next_st.tx_st = tx_stop;
                      next_st.tx_bit = 5'h00;
                      next_st.tx_line = 1'b1;
                    end
                  end else begin
                    next_st.tx_line = st.tx_shift[1];
                  end
                end
                tx_par: begin
                  next_st.tx_st = tx_stop;
                  next_st.tx_bit = 5'h00;
                  next_st.tx_line = 1'b1;
                end
                tx_brk: begin
                  next_st.tx_bit = st.tx_bit + 5'h01;
                  if (st.tx_bit == brk_count - 5'h01) begin
                    next_st.tx_bit = 5'h00;
                    if (st.control[c_brk]) begin
                      next_st.tx_st = tx_start;
                      next_st.tx_line = 1'b0;
                    end else begin
                      next_st.tx_st = tx_stop;
                      next_st.brk_armed = 1'b0;
                      next_st.tx_line = 1'b1;
                    end
                  end
                end
                default: begin
                  next_st.tx_bit = st.tx_bit + 5'h01;
                  if (st.tx_bit[0] == st.format_control_reg[f_stop2]) begin
                    next_st.tx_st = tx_idle;
                    next_st.tx_line = 1'b1;
                    if (st.hold_full) begin
                      next_st.tx_shift = st.tx_hold;
                      next_st.tx_par = st.format_control_reg[f_par_odd];
                      next_st.hold_full = tx_wr;
                      next_st.tx_buffer_empty_flag = next_st.tx_buffer_empty_flag | !tx_wr;
                      next_st.tx_st = tx_start;
                      next_st.tx_tick = 4'h0;
                      next_st.tx_line = 1'b0;
                    end else begin
                      next_st.tx_idle_flag = 1'b1;
                    end
                  end
                end
              endcase
            end
          end
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    if (!st.control[c_rx_en]) begin
      next_st.rx_st = rx_hunt;
      next_st.rx_idle_flag = 1'b1;
    end else if (tick) begin
      next_st.rx_tick = st.rx_tick + 4'h1;
      if (st.rx_tick == tick_vote0) begin
        next_st.votes = {st.votes[1:0], serial_in_pin};
      end
      if (st.rx_tick == tick_mid || st.rx_tick == tick_vote2) begin
        next_st.votes = {st.votes[1:0], serial_in_pin};
      end
      case (st.rx_st)
        rx_hunt: begin
          next_st.rx_tick = 4'h0;
          if (!serial_in_pin) begin
            next_st.rx_st = rx_start;
            next_st.rx_tick = 4'h1;
            next_st.rx_idle_flag = 1'b0;
            next_st.rx_noise = 1'b0;
            next_st.rx_par = st.format_control_reg[f_par_odd];
            next_st.rx_bit = 4'h0;
            next_st.rx_shift_reg = 10'h000;
          end
        end
        rx_wait_h: begin
          next_st.rx_tick = 4'h0;
          if (serial_in_pin) begin
            next_st.rx_st = rx_hunt;
          end
        end
        default: begin
          if (st.rx_tick == tick_last) begin
            if (st.votes != 3'b000 && st.votes != 3'b111) begin
              next_st.rx_noise = 1'b1;
            end
            case (st.rx_st)
              rx_start: begin
                if (vote) begin
                  next_st.rx_st = rx_hunt;
                  next_st.rx_idle_flag = 1'b1;
                end else begin
                  next_st.rx_st = rx_data;
                end
              end
              rx_data: begin
                next_st.rx_shift_reg = word9 ? {1'b0, vote, st.rx_shift_reg[8:1]}
                                             : {2'b00, vote, st.rx_shift_reg[7:1]};
                next_st.rx_par = st.rx_par ^ vote;
                next_st.rx_bit = st.rx_bit + 4'h1;
                if (st.rx_bit == nbits - 4'h1) begin
                  next_st.rx_st = st.format_control_reg[f_par_en] ? rx_par : rx_stop;
                end
              end
              rx_par: begin
                next_st.rx_par = st.rx_par ^ vote;
                next_st.rx_st = rx_stop;
              end
              default: begin
                push = 1'b1;
                inw.data = vote ? st.rx_shift_reg : 10'h000;
                inw.frm = !vote;
                inw.par = st.format_control_reg[f_par_en] & st.rx_par;
                inw.noise = st.rx_noise;
                next_st.rx_idle_flag = 1'b1;
                next_st.rx_st = vote ? rx_hunt : rx_wait_h;
              end
            endcase
          end
        end
      endcase
    end

    // two-entry buffer with overrun discard
    if (pop) begin
      next_st.fifo[0] = st.fifo[1];
      next_st.fifo_cnt = st.fifo_cnt - 2'b01;
      next_st.overrun_flag = 1'b0;
      next_st.noise_flag = 1'b0;
    end
    if (push) begin
      if (next_st.fifo_cnt == 2'b10) begin
        next_st.overrun_flag = 1'b1;
      end else begin
        next_st.fifo[next_st.fifo_cnt[0]] = inw;
        next_st.fifo_cnt = next_st.fifo_cnt + 2'b01;
        next_st.format_control_reg[f_rx9] = inw.data[8];
        next_st.framing_error_flag = inw.frm;
        next_st.parity_error_flag = inw.par;
        if (inw.noise) begin
          next_st.noise_flag = 1'b1;
        end
      end
    end

    next_st.irq = (st.control[c_tx_ie] & st.tx_buffer_empty_flag) |
                  (st.control[c_rx_ie] & ((st.fifo_cnt != 2'b00) | st.overrun_flag));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
      st.format_control_reg <= format_reset;
      st.control <= control_reset;
      st.baud_divider_reg <= baud_reset;
      st.tx_buffer_empty_flag <= 1'b1;
      st.tx_idle_flag <= 1'b1;
      st.rx_idle_flag <= 1'b1;
      st.tx_line <= 1'b1;
      st.tx_st <= tx_idle;
      st.rx_st <= rx_hunt;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = !st.ack;
  assign serial_out_pin  = st.tx_line;
  assign serial_out_oe   = st.tx_oe;
  assign irq             = st.irq;

endmodule

/* tb/async_serial_tx_rx_monitor.sv */
// checker: bus handshake, transmit line timing and irq gating
// assumes the bench sets divider 1, so one bit lasts bit_clks mclk cycles
module async_serial_tx_rx_monitor
  import uart_pkg::*;
#(parameter int bit_clks = 32)
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        irq
);
  logic [15:0] low_run;
  logic [15:0] high_run;
  logic        ctl_wr;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == addr_control
                  && avs_byteenable[0];
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_run  <= 16'h0000;
      high_run <= 16'h0000;
    end else begin
      low_run  <= serial_out_pin ? 16'h0000 : low_run + 16'h0001;
      high_run <= !serial_out_pin ? 16'h0000 :
                  (high_run == 16'hFFFF) ? high_run : high_run + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_wait_answer:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  chk_wait_single:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_oe_follow:
    assert property (ctl_wr |-> ##2 serial_out_oe == $past(avs_writedata[c_tx_en], 2))
    else $error("output enable does not follow tx enable");
  chk_start_enabled:
    assert property ($fell(serial_out_pin) |=> serial_out_oe)
    else $error("frame started with transmitter disabled");
  chk_low_bits:
    assert property ($rose(serial_out_pin) |-> (low_run % bit_clks) == 0)
    else $error("low run is not whole bit times");
  chk_stop_before:
    assert property ($fell(serial_out_pin) |-> high_run >= bit_clks)
    else $error("frame start without a full stop bit before it");
  chk_unmapped_zero:
    assert property (avs_read && !avs_waitrequest && avs_address == 8'h14
                     |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_masked:
    assert property (ctl_wr && avs_writedata[4:3] == 2'b00 |-> ##2 !irq [*3])
    else $error("irq with both enables clear");
  cov_frame: cover property ($fell(serial_out_pin));
  cov_irq: cover property ($rose(irq));
  cov_status: cover property (avs_read && !avs_waitrequest && avs_address == addr_status);
endmodule

bind async_serial_tx_rx async_serial_tx_rx_monitor async_serial_tx_rx_monitor_inst (
  .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .irq(irq)
);

/* tb/serial_peer.sv */
// serial_peer: remote transceiver, sends frames and captures transmitted ones
// assumes one bit is bit_clks mclk cycles; idle line is high
module serial_peer #(parameter int bit_clks = 32) (
  input  wire logic mclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int          nbits = 8;
  logic [10:0] got_q[$];
  logic [10:0] w;
  initial rx_line = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // start bit, n bits lsb first, one stop bit
  task automatic send(input logic [9:0] d, input int n);
    rx_line <= 1'b0;
    repeat (bit_clks) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rx_line <= (i < 10) ? d[i] : 1'b0;
      repeat (bit_clks) @(posedge mclk);
    end
    rx_line <= 1'b1;
    repeat (bit_clks) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // capture: data in [9:0], stop level in [10]
  initial forever begin
    @(posedge mclk);
    if (tx_line === 1'b0) begin
      w = 11'h000;
      repeat (bit_clks / 2) @(posedge mclk);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge mclk);
        w[i] = tx_line;
      end
      repeat (bit_clks) @(posedge mclk);
      w[10] = tx_line;
      got_q.push_back(w);
      while (tx_line !== 1'b1) @(posedge mclk);
    end
  end
endmodule

/* tb/async_serial_tx_rx_tb_top.sv */
// testbench: register traffic over Avalon-MM and frames through the peer
// assumes uart_pkg offsets and status layout; divider set to 1
module async_serial_tx_rx_tb_top import uart_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        serial_out_oe;
  logic        irq;
  logic [31:0] rd;
  int          n_errors = 0;
  int          num_checks = 0;
  logic [31:0] fmt[3] = '{32'h11, 32'h02, 32'h06};
  logic [31:0] txd[3] = '{32'hA5, 32'h07, 32'h07};
  logic [10:0] exw[3] = '{11'h5A5, 11'h507, 11'h407};
  initial forever #10 mclk = ~mclk;
  async_serial_tx_rx async_serial_tx_rx_inst (
    .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .irq(irq));
  serial_peer serial_peer_inst (
    .mclk(mclk), .tx_line(serial_out_oe ? serial_out_pin : 1'b1), .rx_line(serial_in_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin n_errors++; end_sim(); end
    @(posedge mclk);
  endtask
  task automatic poll(input int b);
    int i;
    for (i = 0; i < 500; i++) begin
      bus(0, addr_status, 0);
      if (rd[b] === 1'b1) break;
    end
    if (i == 500) begin n_errors++; end_sim(); end
  endtask
  task automatic wait_rx;
    int i;
    for (i = 0; i < 20000 && serial_peer_inst.got_q.size() == 0; i++) @(posedge mclk);
    if (i == 20000) begin n_errors++; end_sim(); end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    bus(0, addr_status, 0); check(rd, 32'h83);
    bus(0, addr_format, 0); check(rd, 32'h0);
    bus(0, 8'h14, 0); check(rd, 32'h0);
    bus(1, addr_baud, 1);
    avs_byteenable <= 4'hE;
    bus(1, addr_baud, 32'h05);
    avs_byteenable <= 4'hF;
    bus(0, addr_baud, 0);
    check(rd, 32'h1);
    bus(1, addr_control, 32'h0B);
    repeat (2) @(posedge mclk); check(irq, 1);
    bus(1, addr_control, 32'h03);
    repeat (2) @(posedge mclk); check(irq, 0);
    bus(0, addr_status, 0); bus(1, addr_data, 32'h5A);
    bus(0, addr_status, 0); check(rd[1:0], 2'b01);
    bus(1, addr_data, 32'hC3);
    bus(0, addr_status, 0); check(rd[1:0], 2'b00);
    bus(1, addr_data, 32'hFF);
    wait_rx(); check(serial_peer_inst.got_q.pop_front(), 11'h45A);
    wait_rx(); check(serial_peer_inst.got_q.pop_front(), 11'h4C3);
    poll(s_tidle); check(rd[1:0], 2'b11);
    check(serial_peer_inst.got_q.size(), 0);
    serial_peer_inst.nbits = 9;
    foreach (fmt[k]) begin
      bus(1, addr_format, fmt[k]);
      bus(0, addr_status, 0);
      bus(1, addr_data, txd[k]);
      wait_rx(); check(serial_peer_inst.got_q.pop_front(), exw[k]);
      poll(s_tidle);
    end
    bus(1, addr_format, 32'h01);
    serial_peer_inst.send(10'h155, 9);
    poll(s_rxa);
    bus(0, addr_format, 0); check(rd[5], 1);
    bus(0, addr_status, 0); bus(0, addr_data, 0); check(rd[8:0], 9'h155);
    bus(1, addr_format, 0);
    bus(1, addr_control, 32'h13);
    serial_peer_inst.send(10'h11, 8);
    serial_peer_inst.send(10'h22, 8);
    serial_peer_inst.send(10'h33, 8);
    bus(0, addr_status, 0); check(rd[3:2], 2'b11);
    check(irq, 1);
    bus(0, addr_data, 0); check(rd[7:0], 8'h11);
    bus(0, addr_status, 0); bus(0, addr_data, 0); check(rd[7:0], 8'h22);
    bus(0, addr_status, 0); check(rd[3:2], 2'b00);
    serial_peer_inst.send(10'h000, 19);
    poll(s_rxa); check(rd[6], 1);
    bus(0, addr_data, 0); check(rd[8:0], 9'h000);
    serial_peer_inst.send(10'h66, 8);
    poll(s_rxa); bus(0, addr_data, 0); check(rd[7:0], 8'h66);
    serial_peer_inst.nbits = 8;
    bus(1, addr_control, 32'h07);
    wait_rx();
    bus(1, addr_control, 32'h03);
    poll(s_tidle); check(serial_peer_inst.got_q.pop_front(), 11'h000);
    end_sim();
  end
endmodule
